// File: rtl/i2c_input_conditioner.sv
/*
  Synchronises the local I2C SCL and SDA pins, rejects short glitches
  and delays SDA relative to SCL by a programmable hold time.
  Assumes the pins are asynchronous to i_clock.
*/
module i2c_input_conditioner (
  input  wire logic                   i_clock,
  input  wire logic                   i_srst,
  input  wire link_cfg_pkg::i2c_lines_t i_pins,
  input  wire link_cfg_pkg::cond_cfg_t  i_cfg,
  output link_cfg_pkg::i2c_lines_t    o_lines
);
  import link_cfg_pkg::*;

  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  logic [1:0] filt_reg;
  logic [1:0] cnt_reg [2];
  logic [7:0] sda_hist_reg;
  logic [1:0] thr;

  // Cycles a level must persist; the depth field counts 5 ns units.
  assign thr = 2'((int'(i_cfg.depth) * FILTER_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Two flip-flop synchroniser for both lines.
  always_ff @(posedge i_clock)
  begin
    meta_reg <= {i_pins.scl, i_pins.sda};
    sync_reg <= meta_reg;
  end

  // Glitch filter: a change is taken only once it outlasts the threshold.
  always_ff @(posedge i_clock)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (i_srst)
      begin
        filt_reg[i] <= 1'b1;
        cnt_reg[i]  <= 2'h0;
      end
      else if (sync_reg[i] == filt_reg[i])
        cnt_reg[i] <= 2'h0;
      else if (cnt_reg[i] >= thr)
      begin
        filt_reg[i] <= sync_reg[i];
        cnt_reg[i]  <= 2'h0;
      end
      else
        cnt_reg[i] <= cnt_reg[i] + 2'h1;
    end
  end

  // SDA history for the hold delay, one 40 ns step per cycle.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      sda_hist_reg <= 8'hff;
    else
      sda_hist_reg <= {sda_hist_reg[6:0], filt_reg[0]};
  end

  assign o_lines.scl = filt_reg[1];
  // Tap the SDA history at the programmed hold.
  assign o_lines.sda = (i_cfg.hold == 3'h0) ? filt_reg[0]
                                            : sda_hist_reg[i_cfg.hold - 3'h1];

endmodule

// File: rtl/link_control_config_regs.sv
/*
  Configuration and status register slice of a video serializer with
  control channel watchdog, I2C forwarding policy, local I2C pin
  conditioning, master SCL timing, payload and audio modes and the
  back channel error counters.
  Assumes an APB master on i_clock and same-domain control inputs;
  only the I2C pins arrive from outside the clock domain.
*/
// Implementation choice: register access over APB.
module link_control_config_regs #(
  parameter int WD_STEP_CYC = link_cfg_pkg::WD_STEP_CYCLES
) (
  input  wire logic                     i_clock,
  input  wire logic                     i_srst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire link_cfg_pkg::i2c_lines_t i_pins,
  output link_cfg_pkg::i2c_lines_t      o_lines,
  input  wire logic                     i_cc_busy,
  output logic                          o_cc_abort,
  input  wire logic                     i_access_valid,
  input  wire logic [6:0]               i_access_id,
  input  wire logic [6:0]               i_own_id,
  input  wire logic [6:0]               i_remote_deser_id,
  input  wire logic [6:0]               i_remote_target_id,
  output logic                          o_fwd_valid,
  output logic                          o_fwd_pass,
  input  wire logic                     i_master_active,
  output logic                          o_scl_out,
  output logic                          o_scl_oe,
  input  wire logic                     i_stretch_hold,
  output logic                          o_stretch_release,
  output logic                          o_wide_payload_mode,
  input  wire logic                     i_inband_valid,
  input  wire logic                     i_inband_surround,
  output logic                          o_surround_audio,
  input  wire logic                     i_bist_active,
  input  wire logic                     i_bist_start,
  input  wire logic [1:0]               i_bc_crc_error
);
  import link_cfg_pkg::*;

  typedef enum logic [1:0] {
    WD_IDLE    = 2'b00,
    WD_COUNT   = 2'b01,
    WD_EXPIRED = 2'b10
  } wd_state_t;

  typedef enum logic {
    PH_LOW  = 1'b0,
    PH_HIGH = 1'b1
  } scl_phase_t;

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  logic [7:0]  wd_ctl_reg;
  logic [7:0]  fwd_ctl_reg;
  logic [7:0]  scl_high_reg;
  logic [7:0]  scl_low_reg;
  logic [7:0]  payload_ctl_reg;
  logic        port_view_reg;
  logic [7:0]  bc_err_reg [2];
  logic        sw_clear;
  logic        wr_en;
  logic        rd_hit;
  logic [7:0]  rd_byte;
  logic [7:0]  idx;

  wd_state_t   wd_state_reg;
  logic [31:0] wd_cyc_reg;
  logic [6:0]  wd_steps_reg;
  scl_phase_t  scl_phase_reg;
  logic [8:0]  scl_cnt_reg;
  logic [8:0]  setup_cnt_reg;
  cond_cfg_t   cond_cfg;

  // Full length of a timed SCL phase in cycles.
  function automatic logic [8:0] phase_len(input logic [7:0] count);
    phase_len = {1'b0, count} + 9'(SCL_EXTRA_CYC);
  endfunction

  // Register index if the byte address is aligned and in range, else none.
  function automatic logic [7:0] word_index(input logic [11:0] addr);
    word_index = (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) ? addr[9:2] : 8'hff;
  endfunction

  // ****************************************************************
  // APB slave.
  // ****************************************************************
  assign idx     = word_index(paddr);
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign pslverr = psel && penable && !rd_hit;

  // Read decode; unmapped or misaligned addresses raise an error.
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      IDX_RESET_CTL:   rd_byte = 8'h00;
      IDX_WD_CTL:      rd_byte = wd_ctl_reg;
      IDX_FWD_CTL:     rd_byte = fwd_ctl_reg;
      IDX_SCL_HIGH:    rd_byte = scl_high_reg;
      IDX_SCL_LOW:     rd_byte = scl_low_reg;
      IDX_PAYLOAD_CTL: rd_byte = payload_ctl_reg & PAYLOAD_MASK;
      IDX_BC_ERRORS:   rd_byte = bc_err_reg[port_view_reg];
      IDX_PORT_VIEW:   rd_byte = {7'h00, port_view_reg};
      default:         rd_hit = 1'b0;
    endcase
  end

  // Read data is registered during the setup cycle.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= {24'h0, rd_byte};
  end

  // Writable registers, updated in the access phase.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      wd_ctl_reg      <= RST_WD_CTL;
      fwd_ctl_reg     <= RST_FWD_CTL;
      scl_high_reg    <= RST_SCL_HIGH;
      scl_low_reg     <= RST_SCL_LOW;
      payload_ctl_reg <= RST_PAYLOAD_CTL;
      port_view_reg   <= 1'b0;
    end
    else if (wr_en)
    begin
      case (idx)
        IDX_WD_CTL:      wd_ctl_reg <= pwdata[7:0];
        IDX_FWD_CTL:     fwd_ctl_reg <= pwdata[7:0];
        IDX_SCL_HIGH:    scl_high_reg <= pwdata[7:0];
        IDX_SCL_LOW:     scl_low_reg <= pwdata[7:0];
        IDX_PAYLOAD_CTL: payload_ctl_reg <= pwdata[7:0] & PAYLOAD_MASK;
        IDX_PORT_VIEW:   port_view_reg <= pwdata[0];
        default:         ;
      endcase
    end
  end

  // The counter clear bit is a write-only strobe.
  assign sw_clear = wr_en && (idx == IDX_RESET_CTL) && pwdata[POS_BC_CLEAR];

  // ****************************************************************
  // Control channel watchdog.
  // ****************************************************************
  // Steps of 2 ms are counted while a transaction is open; bit 0 stops it.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      wd_state_reg <= WD_IDLE;
      wd_cyc_reg   <= 32'h0;
      wd_steps_reg <= 7'h0;
      o_cc_abort   <= 1'b0;
    end
    else
    begin
      o_cc_abort <= 1'b0;
      case (wd_state_reg)
        WD_IDLE:
        begin
          wd_cyc_reg   <= 32'h0;
          wd_steps_reg <= 7'h0;
          if (i_cc_busy && !wd_ctl_reg[0])
            wd_state_reg <= WD_COUNT;
        end
        WD_COUNT:
        begin
          if (!i_cc_busy || wd_ctl_reg[0])
            wd_state_reg <= WD_IDLE;
          else if (wd_cyc_reg == 32'(WD_STEP_CYC - 1))
          begin
            wd_cyc_reg   <= 32'h0;
            wd_steps_reg <= wd_steps_reg + 7'h1;
            if (wd_steps_reg + 7'h1 >= wd_ctl_reg[7:1])
            begin
              o_cc_abort   <= 1'b1;
              wd_state_reg <= WD_EXPIRED;
            end
          end
          else
            wd_cyc_reg <= wd_cyc_reg + 32'h1;
        end
        WD_EXPIRED:
        begin
          if (!i_cc_busy)
            wd_state_reg <= WD_IDLE;
        end
        default: wd_state_reg <= WD_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // I2C forwarding policy.
  // ****************************************************************
  // One decision per decoded target ID from the local bus.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_fwd_valid <= 1'b0;
      o_fwd_pass  <= 1'b0;
    end
    else
    begin
      o_fwd_valid <= i_access_valid;
      if (i_access_valid)
      begin
        if (fwd_ctl_reg[POS_PASS_ALL])
          o_fwd_pass <= (i_access_id != i_own_id);
        else
          o_fwd_pass <= (i_access_id == i_remote_deser_id) ||
                        (i_access_id == i_remote_target_id);
      end
    end
  end

  // ****************************************************************
  // Local pin conditioning.
  // ****************************************************************
  assign cond_cfg.hold  = fwd_ctl_reg[6:4];
  assign cond_cfg.depth = fwd_ctl_reg[3:0];

  i2c_input_conditioner u_cond (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_pins  (i_pins),
    .i_cfg   (cond_cfg),
    .o_lines (o_lines)
  );

  // ****************************************************************
  // Master SCL timing.
  // ****************************************************************
  // Each phase lasts its count plus five cycles; SCL rests high when idle.
  always_ff @(posedge i_clock)
  begin
    if (i_srst || !i_master_active)
    begin
      scl_phase_reg <= PH_HIGH;
      scl_cnt_reg   <= 9'h0;
    end
    else
    begin
      case (scl_phase_reg)
        PH_HIGH:
        begin
          if (scl_cnt_reg >= phase_len(scl_high_reg) - 9'h1)
          begin
            scl_phase_reg <= PH_LOW;
            scl_cnt_reg   <= 9'h0;
          end
          else
            scl_cnt_reg <= scl_cnt_reg + 9'h1;
        end
        PH_LOW:
        begin
          if (scl_cnt_reg >= phase_len(scl_low_reg) - 9'h1)
          begin
            scl_phase_reg <= PH_HIGH;
            scl_cnt_reg   <= 9'h0;
          end
          else
            scl_cnt_reg <= scl_cnt_reg + 9'h1;
        end
        default: scl_phase_reg <= PH_HIGH;
      endcase
    end
  end

  // Open-drain output: the pin is driven only to pull SCL low.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_scl_oe <= 1'b0;
    else
      o_scl_oe <= i_master_active && (scl_phase_reg == PH_LOW);
  end

  assign o_scl_out = 1'b0;

  // ****************************************************************
  // Target SDA setup before releasing a stretched SCL.
  // ****************************************************************
  // The low count doubles as the setup interval.
  always_ff @(posedge i_clock)
  begin
    if (i_srst || !i_stretch_hold)
    begin
      setup_cnt_reg     <= 9'h0;
      o_stretch_release <= 1'b0;
    end
    else if (setup_cnt_reg >= phase_len(scl_low_reg) - 9'h1)
      o_stretch_release <= 1'b1;
    else
      setup_cnt_reg <= setup_cnt_reg + 9'h1;
  end

  // ****************************************************************
  // Payload and audio modes.
  // ****************************************************************
  // Wide mode follows the payload register; surround follows the in-band flag while it is valid.
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_wide_payload_mode <= 1'b0;
      o_surround_audio    <= 1'b0;
    end
    else
    begin
      o_wide_payload_mode <= payload_ctl_reg[POS_WIDE_MODE];
      o_surround_audio    <= i_inband_valid ? i_inband_surround
                                            : payload_ctl_reg[POS_SURROUND];
    end
  end

  // ****************************************************************
  // Back channel error counters.
  // ****************************************************************
  // Per-port counts saturate; the clear wins over a same-cycle error.
  always_ff @(posedge i_clock)
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (i_srst || i_bist_start || sw_clear)
        bc_err_reg[p] <= 8'h00;
      else if (i_bist_active && i_bc_crc_error[p] && bc_err_reg[p] != BC_ERR_MAX)
        bc_err_reg[p] <= bc_err_reg[p] + 8'h01;
    end
  end

endmodule

// File: shared/link_cfg_pkg.sv
/*
  Holds register indices, reset values, field positions and timing
  constants for the link control configuration register slice.
  Assumes a 25 MHz system clock and APB access with one word per register.
*/
package link_cfg_pkg;

  // ****************************************************************
  // Clock and timing.
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 40;
  localparam int WD_STEP_MS      = 2;
  localparam int WD_STEP_CYCLES  = WD_STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SCL_EXTRA_CYC   = 5;
  localparam int HOLD_UNIT_NS    = 40;
  localparam int FILTER_UNIT_NS  = 5;

  // ****************************************************************
  // Register indices; byte address is four times the index.
  // ****************************************************************
  localparam logic [7:0] IDX_RESET_CTL   = 8'h04;
  localparam logic [7:0] IDX_WD_CTL      = 8'h16;
  localparam logic [7:0] IDX_FWD_CTL     = 8'h17;
  localparam logic [7:0] IDX_SCL_HIGH    = 8'h18;
  localparam logic [7:0] IDX_SCL_LOW     = 8'h19;
  localparam logic [7:0] IDX_PAYLOAD_CTL = 8'h1a;
  localparam logic [7:0] IDX_BC_ERRORS   = 8'h1b;
  localparam logic [7:0] IDX_PORT_VIEW   = 8'h1e;

  // ****************************************************************
  // Reset values and field positions.
  // ****************************************************************
  localparam logic [7:0] RST_WD_CTL      = 8'hfe;
  localparam logic [7:0] RST_FWD_CTL     = 8'h1e;
  localparam logic [7:0] RST_SCL_HIGH    = 8'ha1;
  localparam logic [7:0] RST_SCL_LOW     = 8'ha5;
  localparam logic [7:0] RST_PAYLOAD_CTL = 8'h00;
  localparam logic [7:0] BC_ERR_MAX      = 8'hff;
  localparam int         POS_PASS_ALL    = 7;
  localparam int         POS_WIDE_MODE   = 1;
  localparam int         POS_SURROUND    = 0;
  localparam int         POS_BC_CLEAR    = 5;
  localparam logic [7:0] PAYLOAD_MASK    = 8'h03;

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  typedef struct packed {
    logic scl;
    logic sda;
  } i2c_lines_t;

  typedef struct packed {
    logic [2:0] hold;
    logic [3:0] depth;
  } cond_cfg_t;

endpackage

// File: test/link_cfg_asserts.sv
/*
  Concurrent checks on the top ports of the link configuration slice.
  Assumes it is bound to that module and shares its clock and reset.
*/
module link_cfg_asserts (
  input wire logic       i_clock,
  input wire logic       i_srst,
  input wire logic       i_access_valid,
  input wire logic [6:0] i_access_id,
  input wire logic [6:0] i_own_id,
  input wire logic [6:0] i_remote_deser_id,
  input wire logic [6:0] i_remote_target_id,
  input wire logic       o_fwd_valid,
  input wire logic       o_fwd_pass,
  input wire logic       i_cc_busy,
  input wire logic       o_cc_abort,
  input wire logic       i_master_active,
  input wire logic       o_scl_oe,
  input wire logic       i_stretch_hold,
  input wire logic       o_stretch_release,
  input wire logic       i_inband_valid,
  input wire logic       i_inband_surround,
  input wire logic       o_surround_audio
);
  // ****************************************************************
  // Clocking and phase sequences.
  // ****************************************************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  // A clock phase lasts the five extra periods at least, unless the master stops.
  sequence driven_low;
    o_scl_oe[*5];
  endsequence
  sequence released_high;
    (!o_scl_oe)[*5];
  endsequence
  sequence master_stops;
    ##[0:5] !i_master_active;
  endsequence
  // ****************************************************************
  // Assertions.
  // ****************************************************************
  fwd_pulse_a: assert property (
    1'b1 |=> o_fwd_valid == $past(i_access_valid)) else $error("forward strobe misplaced");
  remote_pass_a: assert property (
    i_access_valid && i_access_id != i_own_id && (i_access_id == i_remote_deser_id ||
    i_access_id == i_remote_target_id) |=> o_fwd_pass) else $error("remote access dropped");
  own_block_a: assert property (
    i_access_valid && i_access_id == i_own_id |=> !o_fwd_pass) else $error("own access sent");
  abort_pulse_a: assert property (
    o_cc_abort |=> !o_cc_abort) else $error("abort wider than one cycle");
  abort_cause_a: assert property (
    o_cc_abort |-> $past(i_cc_busy)) else $error("abort without open transaction");
  scl_low_a: assert property (
    $rose(o_scl_oe) |-> driven_low or master_stops) else $error("clock low phase short");
  scl_high_a: assert property (
    $fell(o_scl_oe) |-> released_high or master_stops) else $error("clock high phase short");
  scl_idle_a: assert property (
    (!i_master_active)[*3] |-> !o_scl_oe) else $error("clock driven while idle");
  release_wait_a: assert property (
    $rose(o_stretch_release) |-> $past(i_stretch_hold, 5)) else $error("release too early");
  release_drop_a: assert property (
    !i_stretch_hold |=> !o_stretch_release) else $error("release kept after hold");
  inband_over_a: assert property (
    i_inband_valid |=> o_surround_audio == $past(i_inband_surround))
    else $error("in-band mode ignored");
endmodule

bind link_control_config_regs link_cfg_asserts u_chk (.*);

// File: test/link_far_side.sv
/*
  Far side model: control channel partner, stretching target and pulled-up pins.
  Assumes requests from the bench arrive as one-cycle pulses.
*/
module link_far_side (
  input  wire logic                 i_clock,
  input  wire logic                 i_srst,
  input  wire logic                 i_go,
  input  wire logic [15:0]          i_len,
  input  wire logic                 i_abort,
  input  wire logic                 i_stretch_go,
  input  wire logic                 i_release,
  input  wire logic                 i_sda_low,
  input  wire logic                 i_scl_low,
  output logic                      o_busy,
  output logic                      o_hold,
  output link_cfg_pkg::i2c_lines_t  o_pins
);
  import link_cfg_pkg::*;
  logic [15:0] left_reg;
  // A transaction stays open for its length; an abort closes it at once.
  always_ff @(posedge i_clock)
  begin
    if (i_srst || i_abort)
      left_reg <= 16'h0;
    else if (i_go)
      left_reg <= i_len;
    else if (left_reg != 16'h0)
      left_reg <= left_reg - 16'h1;
  end
  assign o_busy = (left_reg != 16'h0);
  // The target keeps the clock stretched until the device releases it.
  always_ff @(posedge i_clock)
  begin
    if (i_srst || i_release)
      o_hold <= 1'b0;
    else if (i_stretch_go)
      o_hold <= 1'b1;
  end
  // Pull-ups hold both lines high unless a driver pulls a line low.
  assign o_pins = '{scl: !i_scl_low, sda: !i_sda_low};
endmodule

// File: test/tb.sv
/*
  Self-checking bench for the link configuration slice.
  Assumes the far side model and the bound checker.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import link_cfg_pkg::*;
  typedef struct packed {logic [11:0] a; logic [7:0] d, r; logic err; logic [1:0] m;} row_t;
  row_t rows [8] = '{'{12'h05c, 8'hff, 8'hff, 1'b0, 2'h0}, '{12'h060, 8'h00, 8'h00, 1'b0, 2'h0},
    '{12'h064, 8'hff, 8'hff, 1'b0, 2'h0}, '{12'h06c, 8'h55, 8'h00, 1'b0, 2'h0},
    '{12'h100, 8'h77, 8'h00, 1'b1, 2'h0}, '{12'h068, 8'h02, 8'h02, 1'b0, 2'h2},
    '{12'h068, 8'h01, 8'h01, 1'b0, 2'h1}, '{12'h068, 8'hff, 8'h03, 1'b0, 2'h3}};
  logic [19:0] rst_vals [6] = '{20'h058fe, 20'h05c1e, 20'h060a1, 20'h064a5, 20'h06800, 20'h06c00};
  logic [6:0]  ids [4] = '{7'h10, 7'h20, 7'h30, 7'h40};
  logic        i_clock = 1'b0, i_srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e, i_cc_busy, o_cc_abort, i_access_valid = 1'b0, o_fwd_valid;
  logic        o_fwd_pass, i_master_active = 1'b0, o_scl_out, o_scl_oe, i_stretch_hold;
  logic        o_stretch_release, o_wide_payload_mode, o_surround_audio, i_inband_valid = 1'b0;
  logic        i_inband_surround = 1'b0, i_bist_active = 1'b0, i_bist_start = 1'b0;
  logic        go = 1'b0, sgo = 1'b0, sda_low = 1'b0, ok;
  logic [1:0]  i_bc_crc_error = 2'h0;
  logic [6:0]  i_access_id = 7'h0, i_own_id = 7'h10, i_remote_deser_id = 7'h20;
  logic [6:0]  i_remote_target_id = 7'h30;
  logic [15:0] len = 16'h0;
  i2c_lines_t  i_pins, o_lines;
  int          bad_count = 0, tests_run = 0, cycles = 0, n, lat0;
  link_control_config_regs #(.WD_STEP_CYC(10)) u_dut (.*);
  link_far_side u_far (.i_clock(i_clock), .i_srst(i_srst), .i_go(go), .i_len(len),
    .i_abort(o_cc_abort), .i_stretch_go(sgo), .i_release(o_stretch_release),
    .i_sda_low(sda_low), .i_scl_low(o_scl_oe), .o_busy(i_cc_busy), .o_hold(i_stretch_hold),
    .o_pins(i_pins));
  // ****************************************************************
  // Clock, timeout and shared tasks.
  // ****************************************************************
  initial
    forever #20 i_clock = ~i_clock;
  // A hung wait counts as a mismatch and closes the run.
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer, entered just after a rising edge; read data lands in q.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do @(posedge i_clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clock);
  endtask
  // Opens a transaction and counts cycles to an abort, sixty meaning none.
  task automatic wd_run(input logic [15:0] l, input int lo, input int hi);
    go <= 1'b1;
    len <= l;
    @(posedge i_clock);
    go <= 1'b0;
    n = 0;
    while (o_cc_abort !== 1'b1 && n < 60)
    begin
      @(posedge i_clock);
      n++;
    end
    check("abort cycle", 1, n >= lo && n <= hi);
    while (i_cc_busy !== 1'b0) @(posedge i_clock);
  endtask
  // Counts the length of the next run of the clock enable at one level.
  task automatic oe_run(input logic lvl);
    n = 0;
    while (o_scl_oe !== lvl) @(posedge i_clock);
    while (o_scl_oe === lvl)
    begin
      n++;
      @(posedge i_clock);
    end
  endtask
  // Cycles from pulling data low to the conditioned line following.
  task automatic sda_lat(input logic [2:0] h);
    apb(1'b1, 12'h05c, {25'h0, h, 4'h0});
    repeat (8) @(posedge i_clock); // Let stale low levels leave the hold history.
    sda_low <= 1'b1;
    n = 0;
    while (o_lines.sda !== 1'b0)
    begin
      @(posedge i_clock);
      n++;
    end
    sda_low <= 1'b0;
    while (o_lines.sda !== 1'b1) @(posedge i_clock);
  endtask
  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    repeat (10) @(posedge i_clock);
    i_srst <= 1'b0;
    @(posedge i_clock);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, {24'h0, rows[i].d});
      check("write error", rows[i].err, e);
      apb(1'b0, rows[i].a, 32'h0);
      check("read data", rows[i].r, q);
      check("modes", rows[i].m, {o_wide_payload_mode, o_surround_audio});
    end
    $display("test register rows done");
    i_inband_valid <= 1'b1;
    @(posedge i_clock);
    @(posedge i_clock);
    check("in-band surround", 0, o_surround_audio);
    i_inband_valid <= 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      apb(1'b1, 12'h05c, {24'h0, p[0], 7'h1e});
      foreach (ids[k])
      begin
        i_access_valid <= 1'b1;
        i_access_id <= ids[k];
        @(posedge i_clock);
        i_access_valid <= 1'b0;
        @(posedge i_clock);
        check("fwd valid", 1, o_fwd_valid);
        check("fwd pass", p ? ids[k] != 7'h10 : ids[k] == 7'h20 || ids[k] == 7'h30,
          o_fwd_pass);
      end
    end
    $display("test forwarding done");
    apb(1'b1, 12'h058, 32'h4);
    wd_run(16'hc8, 19, 24);
    wd_run(16'h5, 60, 60);
    apb(1'b1, 12'h058, 32'h5);
    wd_run(16'hc8, 60, 60);
    $display("test watchdog done");
    apb(1'b1, 12'h060, 32'h2);
    apb(1'b1, 12'h064, 32'h3);
    i_master_active <= 1'b1;
    oe_run(1'b1);
    check("scl low run", 8, n);
    check("scl line low", 0, o_lines.scl);
    check("scl data", 0, o_scl_out);
    oe_run(1'b0);
    check("scl high run", 7, n);
    i_master_active <= 1'b0;
    sgo <= 1'b1;
    @(posedge i_clock);
    sgo <= 1'b0;
    while (i_stretch_hold !== 1'b1) @(posedge i_clock);
    n = 0;
    while (o_stretch_release !== 1'b1)
    begin
      @(posedge i_clock);
      n++;
    end
    check("stretch setup", 1, n == 8 || n == 9);
    $display("test clock timing done");
    sda_lat(3'h0);
    lat0 = n;
    sda_lat(3'h7);
    check("sda hold", 7, n - lat0);
    apb(1'b1, 12'h05c, 32'h0f);
    sda_low <= 1'b1;
    @(posedge i_clock);
    sda_low <= 1'b0;
    ok = 1'b1;
    repeat (20)
    begin
      @(posedge i_clock);
      ok = ok && o_lines.sda === 1'b1;
    end
    check("glitch kept out", 1, ok);
    $display("test pin conditioning done");
    i_bist_active <= 1'b1;
    i_bc_crc_error <= 2'h3;
    repeat (3) @(posedge i_clock);
    i_bc_crc_error <= 2'h1;
    repeat (257) @(posedge i_clock);
    i_bc_crc_error <= 2'h0;
    apb(1'b0, 12'h06c, 32'h0);
    check("count saturated", 8'hff, q);
    apb(1'b1, 12'h078, 32'h1);
    apb(1'b0, 12'h06c, 32'h0);
    check("second port count", 8'h03, q);
    apb(1'b1, 12'h010, 32'h20);
    apb(1'b0, 12'h06c, 32'h0);
    check("count cleared", 8'h00, q);
    apb(1'b1, 12'h078, 32'h0);
    i_bc_crc_error <= 2'h1;
    @(posedge i_clock);
    @(posedge i_clock);
    i_bc_crc_error <= 2'h0;
    apb(1'b0, 12'h06c, 32'h0);
    check("count two", 8'h02, q);
    i_bist_start <= 1'b1;
    @(posedge i_clock);
    i_bist_start <= 1'b0;
    apb(1'b0, 12'h06c, 32'h0);
    check("count restarted", 8'h00, q);
    $display("test error counter done");
    i_srst <= 1'b1;
    repeat (10) @(posedge i_clock);
    i_srst <= 1'b0;
    @(posedge i_clock);
    foreach (rst_vals[i])
    begin
      apb(1'b0, rst_vals[i][19:8], 32'h0);
      check("reset value", rst_vals[i][7:0], q);
    end
    $display("test reset values done");
    wrap_up();
  end
endmodule
